// ### rtl/mma_mpu_mem.sv
// How it works
// - CPU clock rate from 3-bit divider code and two range selects; 110 equals 111.
// - 64 KB program space, read for instruction fetch and code-table loads.
// - Program addresses above 0x7FFF use the 3-bit code bank select.
// - After reset release the first fetch vector is address zero.
// - Interrupt vectors sit every eight bytes, starting at address three.
// - 4 KB shared RAM from zero; compute engine normally owns lowest kilobyte.
// - Converter keeps writing lowest 64 bytes; software writes there are dropped.
// - External data read only by external-move instructions; written only by them and the converter.
// - Paged moves use page register high byte and bank R0 or R1 (ri select) low byte.
// - Pointer moves use the full 16-bit selected data pointer.
// - Pointer select bit 0 picks primary (0) or secondary (1) pointer.
// - Changing select keeps both pointers; pointer operations act on selected one.
// - Page register supplies high byte for both paged reads and writes.
// - Only mapped ranges respond; battery window sits inside configuration RAM.
// - Internal data memory is 256 bytes with byte-wide addresses.
// - Direct upper addresses reach SFRs; indirect ones reach upper RAM.
// - Lowest 32 bytes are four register banks chosen by two status bits.
// - Bytes 0x20-0x2F bit addressable; lower half reachable directly and indirectly.
`timescale 1ns/1ps
`default_nettype none
module mma_mpu_mem
  import mma_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [2:0]  i_cpu_clock_divider,
  input  wire logic        i_master_clock_high_range,
  input  wire logic        i_master_clock_mid_range,
  output logic             o_cpu_clock_en,
  input  wire logic        i_code_req,
  input  wire logic        i_code_movc,
  input  wire logic [15:0] i_code_addr,
  output logic             o_flash_rd,
  output logic             o_flash_movc,
  output logic [17:0]      o_flash_addr,
  input  wire logic        i_irq_take,
  input  wire logic [2:0]  i_irq_index,
  output logic             o_vector_valid,
  output logic [15:0]      o_vector_addr,
  input  wire logic        i_idata_req,
  input  wire logic        i_idata_we,
  input  wire logic        i_idata_indirect,
  input  wire logic [7:0]  i_idata_addr,
  input  wire logic [7:0]  i_idata_wdata,
  output logic [7:0]       o_idata_rdata,
  output logic             o_sfr_ext,
  input  wire logic        i_bit_req,
  input  wire logic        i_bit_we,
  input  wire logic [7:0]  i_bit_addr,
  input  wire logic        i_bit_wdata,
  output logic             o_bit_rdata,
  input  wire logic        i_primary_data_pointer_load,
  input  wire logic [15:0] i_primary_data_pointer_ldata,
  input  wire logic        i_primary_data_pointer_inc,
  input  wire logic        i_xdata_req,
  input  wire logic        i_xdata_we,
  input  wire logic        i_xdata_use_primary_data_pointer,
  input  wire logic        i_xdata_ri_sel,
  input  wire logic [7:0]  i_xdata_wdata,
  output logic             o_xdata_ready,
  output logic             o_xdata_blocked,
  output logic             o_xdata_ce_area,
  input  wire logic        i_conv_wr,
  input  wire logic [5:0]  i_conv_addr,
  input  wire logic [7:0]  i_conv_wdata,
  output logic             o_mem_re,
  output logic             o_mem_we,
  output logic [15:0]      o_mem_addr,
  output logic [7:0]       o_mem_wdata,
  output mma_xtgt_t        o_mem_target
);
  // ==========================================================
  // Functions
  function automatic logic [7:0] sfr_read(input logic [7:0] a, input logic [15:0] d0,
    input logic [15:0] d1, input logic [7:0] sel, input logic [7:0] bank,
    input logic [7:0] page, input logic [7:0] program_status_word);
    logic [7:0] r;
    r = RST_BYTE;
    case (a)
      SFR_DPL0:      r = d0[7:0];
      SFR_DPH0:      r = d0[15:8];
      SFR_DPL1:      r = d1[7:0];
      SFR_DPH1:      r = d1[15:8];
      SFR_PTR_SEL:   r = sel;
      SFR_CODE_BANK: r = bank;
      SFR_PAGE_HIGH: r = page;
      SFR_PSW:       r = program_status_word;
      default:       r = RST_BYTE;
    endcase
    return r;
  endfunction

  function automatic logic sfr_held(input logic [7:0] a);
    return (a == SFR_DPL0) || (a == SFR_DPH0) || (a == SFR_DPL1) || (a == SFR_DPH1) ||
           (a == SFR_PTR_SEL) || (a == SFR_CODE_BANK) || (a == SFR_PAGE_HIGH) ||
           (a == SFR_PSW);
  endfunction

  function automatic logic [7:0] bit_byte_addr(input logic [7:0] b);
    return b[7] ? {b[7:3], 3'h0} : (BIT_AREA_BASE + {4'h0, b[6:3]});
  endfunction

  function automatic mma_xtgt_t xdata_target(input logic [15:0] a);
    if (a <= SHARED_DATA_RAM_LAST) return MMA_XT_SHARED_DATA_RAM;
    if (a >= BATT_FIRST && a <= BATT_LAST) return MMA_XT_BATT;
    if (a >= CFG_FIRST && a <= CFG_LAST) return MMA_XT_CFG;
    return MMA_XT_NONE;
  endfunction

  // ==========================================================
  // Reset release
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ==========================================================
  // CPU clock enable
  mma_clk_if clk_if ();

  assign clk_if.div        = i_cpu_clock_divider;
  assign clk_if.high_range = i_master_clock_high_range;
  assign clk_if.mid_range  = i_master_clock_mid_range;
  assign o_cpu_clock_en    = clk_if.en;

  mma_clkgen u_clkgen (
    .i_clk   (i_clk),
    .i_rst_n (rst_n_r),
    .clk_io  (clk_if.gen)
  );

  // ==========================================================
  // Registers and storage
  logic [7:0]  iram_r [IRAM_BYTES];
  logic [15:0] dptr0_r;
  logic [15:0] secondary_data_pointer_r;
  logic [15:0] dptr0_nxt;
  logic [15:0] secondary_data_pointer_nxt;
  logic [7:0]  ptr_sel_r;
  logic [7:0]  ptr_sel_nxt;
  logic [7:0]  bank_r;
  logic [7:0]  bank_nxt;
  logic [7:0]  page_r;
  logic [7:0]  page_nxt;
  logic [7:0]  psw_r;
  logic [7:0]  psw_nxt;

  // ==========================================================
  // Internal data decode
  logic       idata_wr;
  logic       sfr_dir;
  logic       bit_wr;
  logic       bit_sfr;
  logic [7:0] bit_byte;
  logic [7:0] bit_cur;
  logic [7:0] bit_new;
  logic [7:0] idata_sfr_rd;
  logic       sfr_we;
  logic [7:0] sfr_waddr;
  logic [7:0] sfr_wdata;
  logic       iram_we;
  logic [7:0] iram_waddr;
  logic [7:0] iram_wdata;

  assign idata_wr     = i_idata_req & i_idata_we;
  assign sfr_dir      = ~i_idata_indirect & (i_idata_addr >= IRAM_UPPER);
  assign bit_wr       = i_bit_req & i_bit_we & ~idata_wr;
  assign bit_sfr      = i_bit_addr[7];
  assign bit_byte     = bit_byte_addr(i_bit_addr);
  assign bit_cur      = bit_sfr ? sfr_read(bit_byte, dptr0_r, secondary_data_pointer_r, ptr_sel_r, bank_r, page_r, psw_r)
                                : iram_r[bit_byte];
  assign idata_sfr_rd = sfr_read(i_idata_addr, dptr0_r, secondary_data_pointer_r, ptr_sel_r, bank_r, page_r, psw_r);
  // Bit write is a read-modify-write of the whole byte
  always_comb begin
    bit_new = bit_cur;
    bit_new[i_bit_addr[2:0]] = i_bit_wdata;
  end

  // Byte write wins over a bit write in the same cycle
  assign sfr_we     = (idata_wr & sfr_dir) | (bit_wr & bit_sfr);
  assign sfr_waddr  = idata_wr ? i_idata_addr : bit_byte;
  assign sfr_wdata  = idata_wr ? i_idata_wdata : bit_new;
  assign iram_we    = (idata_wr & ~sfr_dir) | (bit_wr & ~bit_sfr);
  assign iram_waddr = idata_wr ? i_idata_addr : bit_byte;
  assign iram_wdata = idata_wr ? i_idata_wdata : bit_new;

  // ==========================================================
  // SFR next state
  logic [15:0] primary_data_pointer_cur;
  logic        sel_hi;

  assign sel_hi   = ptr_sel_r[PTR_SEL_BIT];
  assign primary_data_pointer_cur = sel_hi ? secondary_data_pointer_r : dptr0_r;

  always_comb begin
    dptr0_nxt   = dptr0_r;
    secondary_data_pointer_nxt   = secondary_data_pointer_r;
    ptr_sel_nxt = ptr_sel_r;
    bank_nxt    = bank_r;
    page_nxt    = page_r;
    psw_nxt     = psw_r;
    if (sfr_we) begin
      case (sfr_waddr)
        SFR_DPL0:      dptr0_nxt[7:0]  = sfr_wdata;
        SFR_DPH0:      dptr0_nxt[15:8] = sfr_wdata;
        SFR_DPL1:      secondary_data_pointer_nxt[7:0]  = sfr_wdata;
        SFR_DPH1:      secondary_data_pointer_nxt[15:8] = sfr_wdata;
        SFR_PTR_SEL:   ptr_sel_nxt     = sfr_wdata;
        SFR_CODE_BANK: bank_nxt        = sfr_wdata;
        SFR_PAGE_HIGH: page_nxt        = sfr_wdata;
        SFR_PSW:       psw_nxt         = sfr_wdata;
        default:       psw_nxt         = psw_r;
      endcase
    end
    // Pointer operations follow the select bit as it stands now
    if (i_primary_data_pointer_load) begin
      if (sel_hi) begin
        secondary_data_pointer_nxt = i_primary_data_pointer_ldata;
      end else begin
        dptr0_nxt = i_primary_data_pointer_ldata;
      end
    end else if (i_primary_data_pointer_inc) begin
      if (sel_hi) begin
        secondary_data_pointer_nxt = secondary_data_pointer_r + 16'h0001;
      end else begin
        dptr0_nxt = dptr0_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dptr0_r   <= RST_PRIMARY_DATA_POINTER;
      secondary_data_pointer_r   <= RST_PRIMARY_DATA_POINTER;
      ptr_sel_r <= RST_BYTE;
      bank_r    <= RST_BYTE;
      page_r    <= RST_BYTE;
      psw_r     <= RST_BYTE;
    end else begin
      dptr0_r   <= dptr0_nxt;
      secondary_data_pointer_r   <= secondary_data_pointer_nxt;
      ptr_sel_r <= ptr_sel_nxt;
      bank_r    <= bank_nxt;
      page_r    <= page_nxt;
      psw_r     <= psw_nxt;
    end
  end

  // Storage only, so no reset: software initialises it
  always_ff @(posedge i_clk) begin
    if (iram_we) begin
      iram_r[iram_waddr] <= iram_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_idata_rdata <= RST_BYTE;
      o_sfr_ext     <= 1'b0;
      o_bit_rdata   <= 1'b0;
    end else begin
      o_idata_rdata <= sfr_dir ? idata_sfr_rd : iram_r[i_idata_addr];
      o_sfr_ext     <= i_idata_req & sfr_dir & ~sfr_held(i_idata_addr);
      o_bit_rdata   <= bit_cur[i_bit_addr[2:0]];
    end
  end

  // ==========================================================
  // Program space
  logic [17:0] flash_addr_nxt;

  assign flash_addr_nxt = i_code_addr[CODE_WIN_BIT] ? {bank_r[BANK_W-1:0], i_code_addr[14:0]}
                                                    : {3'h0, i_code_addr[14:0]};

  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_flash_rd   <= 1'b0;
      o_flash_movc <= 1'b0;
      o_flash_addr <= '0;
    end else begin
      o_flash_rd   <= i_code_req;
      o_flash_movc <= i_code_req & i_code_movc;
      if (i_code_req) begin
        o_flash_addr <= flash_addr_nxt;
      end
    end
  end

  // ==========================================================
  // Vectors
  mma_boot_t   boot_r;
  mma_boot_t   boot_nxt;
  logic [15:0] irq_vec;

  assign irq_vec = VEC_BASE + {10'h000, i_irq_index, 3'h0};

  always_comb begin
    unique case (boot_r)
      BOOT_WAIT:  boot_nxt = o_cpu_clock_en ? BOOT_ISSUE : BOOT_WAIT;
      BOOT_ISSUE: boot_nxt = BOOT_RUN;
      BOOT_RUN:   boot_nxt = BOOT_RUN;
      default:    boot_nxt = BOOT_WAIT;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      boot_r         <= BOOT_WAIT;
      o_vector_valid <= 1'b0;
      o_vector_addr  <= RESET_VECTOR;
    end else begin
      boot_r         <= boot_nxt;
      o_vector_valid <= (boot_r == BOOT_ISSUE) | ((boot_r == BOOT_RUN) & i_irq_take);
      if (boot_r == BOOT_ISSUE) begin
        o_vector_addr <= RESET_VECTOR;
      end else if (boot_r == BOOT_RUN && i_irq_take) begin
        o_vector_addr <= irq_vec;
      end
    end
  end

  // ==========================================================
  // External data moves
  logic [7:0]  ri_idx;
  logic [7:0]  ri_byte;
  logic [15:0] xaddr;
  mma_xtgt_t   xtgt;
  logic        conv_zone;

  assign ri_idx        = {3'h0, psw_r[PSW_RS_LSB +: 2], 2'h0, i_xdata_ri_sel};
  assign ri_byte       = iram_r[ri_idx];
  assign xaddr         = i_xdata_use_primary_data_pointer ? primary_data_pointer_cur : {page_r, ri_byte};
  assign xtgt          = xdata_target(xaddr);
  assign conv_zone     = (xaddr <= CONV_LAST);
  // Converter owns the port; the core waits
  assign o_xdata_ready = ~i_conv_wr;

  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_mem_re        <= 1'b0;
      o_mem_we        <= 1'b0;
      o_mem_addr      <= '0;
      o_mem_wdata     <= RST_BYTE;
      o_mem_target    <= MMA_XT_NONE;
      o_xdata_blocked <= 1'b0;
      o_xdata_ce_area <= 1'b0;
    end else if (i_conv_wr) begin
      o_mem_re        <= 1'b0;
      o_mem_we        <= 1'b1;
      o_mem_addr      <= {10'h000, i_conv_addr};
      o_mem_wdata     <= i_conv_wdata;
      o_mem_target    <= MMA_XT_SHARED_DATA_RAM;
      o_xdata_blocked <= 1'b0;
      o_xdata_ce_area <= 1'b0;
    end else begin
      o_mem_re        <= i_xdata_req & ~i_xdata_we & (xtgt != MMA_XT_NONE);
      o_mem_we        <= i_xdata_req & i_xdata_we & (xtgt != MMA_XT_NONE) & ~conv_zone;
      o_xdata_blocked <= i_xdata_req & i_xdata_we & conv_zone;
      o_xdata_ce_area <= i_xdata_req & (xaddr <= CE_LAST);
      if (i_xdata_req) begin
        o_mem_addr   <= xaddr;
        o_mem_wdata  <= i_xdata_wdata;
        o_mem_target <= xtgt;
      end
    end
  end

  // ==========================================================
  // Checks
  chk_clk_no_burst: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    o_cpu_clock_en |=> !o_cpu_clock_en) else $error("cpu clock enable above 10 MHz");
  chk_flash_low_half: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    i_code_req && !i_code_addr[15] |=> o_flash_rd && o_flash_addr == {3'h0, $past(i_code_addr[14:0])})
    else $error("low program read misplaced");
  chk_bank_window: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    i_code_req && i_code_addr[15] |=> o_flash_addr[17:15] == $past(bank_r[2:0]))
    else $error("bank not applied");
  chk_boot_vector: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    boot_r == BOOT_ISSUE |=> o_vector_valid && o_vector_addr == 16'h0000)
    else $error("boot vector wrong");
  chk_irq_vector: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    boot_r == BOOT_RUN && i_irq_take |=> o_vector_addr == 16'h0003 + 16'($past(i_irq_index)) * 16'h0008)
    else $error("interrupt vector wrong");
  chk_conv_zone: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    i_xdata_req && i_xdata_we && !i_conv_wr && xaddr <= 16'h003F |=> !o_mem_we && o_xdata_blocked)
    else $error("write reached converter area");
  chk_xdata_only: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    !i_xdata_req && !i_conv_wr |=> !o_mem_we && !o_mem_re) else $error("stray data RAM strobe");
  chk_paged_addr: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    i_xdata_req && !i_xdata_use_primary_data_pointer && !i_conv_wr |=> o_mem_addr == {$past(page_r), $past(ri_byte)})
    else $error("paged address wrong");
  chk_primary_data_pointer_addr: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    i_xdata_req && i_xdata_use_primary_data_pointer && !i_conv_wr |=> o_mem_addr == $past(primary_data_pointer_cur))
    else $error("pointer address wrong");
  chk_sel_keeps: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    sfr_we && sfr_waddr == SFR_PTR_SEL && !i_primary_data_pointer_load && !i_primary_data_pointer_inc |=> $stable(dptr0_r) && $stable(secondary_data_pointer_r))
    else $error("select changed a pointer");
  chk_inc_selected: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    i_primary_data_pointer_inc && !i_primary_data_pointer_load && !sfr_we && sel_hi |=> secondary_data_pointer_r == $past(secondary_data_pointer_r) + 16'h0001 && $stable(dptr0_r))
    else $error("increment hit wrong pointer");
  chk_batt_window: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    i_xdata_req && !i_conv_wr && xaddr >= 16'h20C0 && xaddr <= 16'h20C7 |=> o_mem_target == MMA_XT_BATT)
    else $error("battery window missed");
  chk_indirect_ram: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    idata_wr && i_idata_indirect |=> iram_r[$past(i_idata_addr)] == $past(i_idata_wdata))
    else $error("indirect write missed RAM");
  chk_bit_area: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    i_bit_req && !i_bit_addr[7] |-> bit_byte >= 8'h20 && bit_byte <= 8'h2F) else $error("bit byte outside area");
endmodule // mma_mpu_mem
`default_nettype wire

// ### rtl/mma_pkg.sv
package mma_pkg;
  // ==========================================================
  // SFR addresses
  localparam logic [7:0]  SFR_DPL0      = 8'h82;
  localparam logic [7:0]  SFR_DPH0      = 8'h83;
  localparam logic [7:0]  SFR_DPL1      = 8'h84;
  localparam logic [7:0]  SFR_DPH1      = 8'h85;
  localparam logic [7:0]  SFR_PTR_SEL   = 8'h92;
  localparam logic [7:0]  SFR_CODE_BANK = 8'hB6;
  localparam logic [7:0]  SFR_PAGE_HIGH = 8'hBF;
  localparam logic [7:0]  SFR_PSW       = 8'hD0;
  // ==========================================================
  // Reset values and fields
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_PRIMARY_DATA_POINTER      = 16'h0000;
  localparam int          PTR_SEL_BIT   = 0;
  localparam int          PSW_RS_LSB    = 3;
  localparam int          BANK_W        = 3;
  localparam int          CODE_WIN_BIT  = 15;
  // ==========================================================
  // Program space
  localparam logic [15:0] RESET_VECTOR  = 16'h0000;
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam int          VEC_STRIDE_SH = 3;
  // ==========================================================
  // External data space
  localparam logic [15:0] CONV_LAST     = 16'h003F;
  localparam logic [15:0] CE_LAST       = 16'h03FF;
  localparam logic [15:0] SHARED_DATA_RAM_LAST     = 16'h0FFF;
  localparam logic [15:0] CFG_FIRST     = 16'h2000;
  localparam logic [15:0] CFG_LAST      = 16'h20FF;
  localparam logic [15:0] BATT_FIRST    = 16'h20C0;
  localparam logic [15:0] BATT_LAST     = 16'h20C7;
  // ==========================================================
  // Internal data space
  localparam int          IRAM_BYTES    = 256;
  localparam logic [7:0]  IRAM_UPPER    = 8'h80;
  localparam logic [7:0]  BIT_AREA_BASE = 8'h20;
  // ==========================================================
  // CPU clock rates
  localparam int          RATE_W        = 26;
  localparam logic [25:0] SYS_CLK_HZ    = 26'd25000000;
  localparam logic [25:0] CPU_HIGH_HZ   = 26'd10000000;
  localparam logic [25:0] CPU_MID_HZ    = 26'd6600000;
  localparam logic [25:0] CPU_LOW_HZ    = 26'd5000000;
  localparam logic [2:0]  DIV_SLOWEST   = 3'h6;

  typedef enum logic [1:0] {
    MMA_XT_NONE = 2'b00,
    MMA_XT_SHARED_DATA_RAM = 2'b01,
    MMA_XT_CFG  = 2'b10,
    MMA_XT_BATT = 2'b11
  } mma_xtgt_t;

  typedef enum logic [1:0] {
    BOOT_WAIT  = 2'b00,
    BOOT_ISSUE = 2'b01,
    BOOT_RUN   = 2'b10
  } mma_boot_t;
endpackage

// ### rtl/mma_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mma_clk_if;
  logic [2:0] div;
  logic       high_range;
  logic       mid_range;
  logic       en;
  modport gen  (input div, input high_range, input mid_range, output en);
  modport user (output div, output high_range, output mid_range, input en);
endinterface
`default_nettype wire

// ### rtl/mma_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
module mma_clkgen
  import mma_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  mma_clk_if.gen    clk_io
);
  // ==========================================================
  // Phase accumulator
  // Exact average rate; pulses jitter by one system cycle.
  logic [RATE_W-1:0] acc_r;
  logic [RATE_W-1:0] acc_nxt;
  logic [RATE_W-1:0] base_rate;
  logic [RATE_W-1:0] rate;
  logic [RATE_W-1:0] sum;
  logic [2:0]        shift;
  logic              en_r;
  logic              en_nxt;

  assign base_rate = clk_io.high_range ? CPU_HIGH_HZ :
                     (clk_io.mid_range ? CPU_MID_HZ : CPU_LOW_HZ);
  assign shift     = (clk_io.div > DIV_SLOWEST) ? DIV_SLOWEST : clk_io.div;
  assign rate      = base_rate >> shift;
  assign sum       = acc_r + rate;
  assign en_nxt    = (sum >= SYS_CLK_HZ);
  assign acc_nxt   = en_nxt ? (sum - SYS_CLK_HZ) : sum;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_r <= '0;
      en_r  <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      en_r  <= en_nxt;
    end
  end

  assign clk_io.en = en_r;

  chk_slow_codes_same: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    clk_io.div == 3'h7 |-> rate == (base_rate >> DIV_SLOWEST))
    else $error("codes 110 and 111 differ");
endmodule // mma_clkgen
`default_nettype wire

// ### test/mma_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mma_mem_model
  import mma_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_we,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire mma_xtgt_t   i_target
);
  // ==========================================================
  // Shared RAM image, only writes targeting shared RAM land
  logic [7:0] mem [0:4095];
  always @(posedge i_clk) begin
    if (i_we && i_target == MMA_XT_SHARED_DATA_RAM) begin
      mem[i_addr[11:0]] <= i_wdata;
    end
  end
endmodule // mma_mem_model
`default_nettype wire

// ### test/mma_mpu_mem_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mma_mpu_mem_tb;
  import mma_pkg::*;
  logic i_clk = 0, i_rst_n = 0, o_cpu_clock_en, o_flash_rd, o_flash_movc;
  logic o_vector_valid, o_sfr_ext, o_bit_rdata, o_xdata_ready, o_xdata_blocked;
  logic o_xdata_ce_area, o_mem_re, o_mem_we, irq = 0, creq = 0, movc = 0;
  logic ireq = 0, iwe = 0, dld = 0, dinc = 0, xreq = 0, xwe = 0, xdp = 0, xri = 0, cw = 0, blk, ce, ext;
  logic hr = 1, mr = 0, ind = 0, breq = 0, bwe = 0, bwd = 0;
  logic [2:0]  div = 0, idx = 0;
  logic [7:0]  iad = 0, iwd = 0, xwd = 0, cwd = 0, o_idata_rdata, o_mem_wdata, rb, bad = 0, w0;
  logic [15:0] cad = 0, dld_v = 0, o_vector_addr, o_mem_addr, r = 16'd48775, v;
  logic [17:0] o_flash_addr, vq[$], fq[$], mq[$];
  mma_xtgt_t   o_mem_target;
  int          failures = 0, check_count = 0, cyc = 0;
  mma_mpu_mem mma_mpu_mem_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cpu_clock_divider(div),
    .i_master_clock_high_range(hr), .i_master_clock_mid_range(mr), .o_cpu_clock_en(o_cpu_clock_en),
    .i_code_req(creq), .i_code_movc(movc), .i_code_addr(cad), .o_flash_rd(o_flash_rd),
    .o_flash_movc(o_flash_movc), .o_flash_addr(o_flash_addr), .i_irq_take(irq), .i_irq_index(idx),
    .o_vector_valid(o_vector_valid), .o_vector_addr(o_vector_addr), .i_idata_req(ireq),
    .i_idata_we(iwe), .i_idata_indirect(ind), .i_idata_addr(iad), .i_idata_wdata(iwd),
    .o_idata_rdata(o_idata_rdata), .o_sfr_ext(o_sfr_ext), .i_bit_req(breq), .i_bit_we(bwe),
    .i_bit_addr(bad), .i_bit_wdata(bwd), .o_bit_rdata(o_bit_rdata), .i_primary_data_pointer_load(dld),
    .i_primary_data_pointer_ldata(dld_v), .i_primary_data_pointer_inc(dinc), .i_xdata_req(xreq), .i_xdata_we(xwe),
    .i_xdata_use_primary_data_pointer(xdp), .i_xdata_ri_sel(xri), .i_xdata_wdata(xwd), .o_xdata_ready(o_xdata_ready),
    .o_xdata_blocked(o_xdata_blocked), .o_xdata_ce_area(o_xdata_ce_area), .i_conv_wr(cw),
    .i_conv_addr(6'h05), .i_conv_wdata(cwd), .o_mem_re(o_mem_re), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_target(o_mem_target));
  mma_mem_model mma_mem_model_i (.i_clk(i_clk), .i_we(o_mem_we), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .i_target(o_mem_target));
  // ==========================================================
  // Clock, reset, timeout
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic take(ref logic [17:0] q[$], input logic [17:0] got);
    if (q.size() == 0) cmp(got, 18'h3FFFF);
    else cmp(got, q.pop_front());
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      wrap_up();
    end
  end
  // ==========================================================
  // Result watcher; strobes stand one cycle, sampled mid-cycle
  always @(negedge i_clk) begin
    if (o_vector_valid) take(vq, {2'b00, o_vector_addr});
    if (o_flash_rd) take(fq, o_flash_addr);
    if (o_mem_re || o_mem_we) take(mq, {o_mem_target, o_mem_addr});
  end
  // ==========================================================
  // Drivers, all changes at falling edge
  task automatic step();
    @(negedge i_clk);
  endtask
  task automatic sfr(input logic [7:0] a, input logic [7:0] d);
    ireq = 1; iwe = 1; iad = a; iwd = d;
    step(); ireq = 0; iwe = 0; ext = o_sfr_ext; step();
  endtask
  task automatic xd(input logic w, input logic dp, input logic ri, input logic [17:0] e, input logic ex);
    if (ex) mq.push_back(e);
    xreq = 1; xwe = w; xdp = dp; xri = ri; xwd = r[7:0];
    step(); xreq = 0; blk = o_xdata_blocked; ce = o_xdata_ce_area; step();
  endtask
  // Pulses in n cycles; n chosen so n * rate / system clock is a whole number of pulses
  task automatic clk_rate(input logic h, input logic m, input logic [2:0] d, input int n, input int e);
    int c;
    c = 0;
    hr = h; mr = m; div = d;
    repeat (n) begin
      step();
      if (o_cpu_clock_en) c++;
    end
    cmp(18'(c), 18'(e));
  endtask
  initial begin
    repeat (16) step();
    vq.push_back(18'h00000);
    i_rst_n = 1;
    repeat (30) step();
    $display("boot done");
    for (int i = 0; i < 8; i++) begin
      vq.push_back(18'h00003 + 18'(8 * i));
      irq = 1; idx = 3'(i); step(); irq = 0; step();
    end
    $display("vectors done");
    sfr(SFR_CODE_BANK, 8'h05);
    fq.push_back(18'h29234); creq = 1; cad = 16'h9234; step();
    fq.push_back(18'h01234); movc = 1; cad = 16'h1234; step();
    cmp({17'h0, o_flash_movc}, 18'h1);
    creq = 0; movc = 0; step();
    $display("program done");
    sfr(SFR_DPL0, 8'h00); sfr(SFR_DPH0, 8'h01); w0 = r[7:0];
    xd(1, 1, 0, {2'b01, 16'h0100}, 1);
    cmp({17'h0, ce}, 18'h1);
    rb = r[7:0]; r = lfsr(r); v = {6'h01, r[9:0]};
    sfr(SFR_PTR_SEL, 8'h01);
    dld = 1; dld_v = v; step(); dld = 0; dinc = 1; step(); dinc = 0; step();
    xd(0, 1, 0, {2'b01, v + 16'h0001}, 1);
    sfr(SFR_PTR_SEL, 8'h00);
    xd(0, 1, 0, {2'b01, 16'h0100}, 1);
    $display("pointers done");
    r = lfsr(r); rb = r[7:0];
    sfr(SFR_PSW, 8'h08); sfr(8'h09, rb); sfr(SFR_PAGE_HIGH, 8'h0A);
    xd(0, 0, 1, {2'b01, 8'h0A, rb}, 1);
    xd(1, 0, 1, {2'b01, 8'h0A, rb}, 1);
    sfr(SFR_PAGE_HIGH, 8'h20); sfr(8'h09, 8'hC3);
    xd(0, 0, 1, {2'b11, 16'h20C3}, 1);
    sfr(SFR_PAGE_HIGH, 8'h00); sfr(8'h09, 8'h10);
    xd(1, 0, 1, 18'h0, 0);
    cmp({17'h0, blk}, 18'h1);
    mq.push_back({2'b01, 16'h0005}); cw = 1; cwd = 8'h3C; step();
    cmp({17'h0, o_xdata_ready}, 18'h0);
    cw = 0; step(); step();
    cmp({10'h0, mma_mem_model_i.mem[12'h005]}, 18'h0003C);
    $display("paged done");
    sfr(8'h21, 8'h00);
    breq = 1; bwe = 1; bad = 8'h0B; bwd = 1; step(); breq = 0; bwe = 0; step();
    cmp({10'h0, o_idata_rdata}, 18'h00008);
    cmp({17'h0, o_bit_rdata}, 18'h1);
    ind = 1; sfr(8'h92, 8'h5A);
    cmp({10'h0, o_idata_rdata}, 18'h0005A);
    ind = 0; step();
    cmp({10'h0, o_idata_rdata}, 18'h0);
    sfr(8'hA0, 8'h33);
    cmp({17'h0, ext}, 18'h1);
    $display("internal done");
    clk_rate(1, 0, 0, 100, 40);
    clk_rate(0, 1, 0, 250, 66);
    clk_rate(0, 0, 7, 320, 1);
    clk_rate(1, 1, 6, 160, 1);
    $display("clock done");
    cmp({10'h0, mma_mem_model_i.mem[12'h100]}, {10'h0, w0});
    cmp(18'(vq.size() + fq.size() + mq.size()), 18'h0);
    wrap_up();
  end
endmodule // mma_mpu_mem_tb
`default_nettype wire
